// *** src/eoas_pkg.sv ***
// eoas_pkg: constants shared by both ends of the object-access link.
// assumes one 100 MHz core clock; frames are exchanged whole, not bit by bit.
package eoas_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // command bytes (byte 0 of every 8-byte request and reply)
   localparam logic [7:0] CMD_READ = 8'h40;
   localparam logic [7:0] CMD_WRITE = 8'h22;
   localparam logic [7:0] CMD_READ_ANS = 8'h43;
   localparam logic [7:0] CMD_WRITE_ANS = 8'h60;
   localparam logic [7:0] CMD_ABORT = 8'h80;

   ////////////////////////////////////////////////////////////////////////////
   // identifier bases, added to the station number
   localparam logic [10:0] ID_REQ_BASE = 11'h600;
   localparam logic [10:0] ID_RSP_BASE = 11'h580;
   localparam logic [10:0] ID_BOOT_BASE = 11'h700;

   ////////////////////////////////////////////////////////////////////////////
   // object indices
   localparam logic [15:0] IDX_POSITION = 16'h2000;
   localparam logic [15:0] IDX_STEPS = 16'h2101;
   localparam logic [15:0] IDX_SPAN = 16'h2102;
   localparam logic [15:0] IDX_STORE = 16'h2300;
   localparam logic [15:0] IDX_STATION = 16'h3000;
   localparam logic [15:0] IDX_RATE = 16'h3001;
   localparam logic [15:0] IDX_SERIAL = 16'h650B;
   localparam logic [15:0] IDX_PRESET = 16'h6003;
   localparam logic [15:0] IDX_POS_ALIAS = 16'h6004;

   ////////////////////////////////////////////////////////////////////////////
   // field positions inside the 64-bit payload, byte 0 in the low bits
   localparam int CMD_LSB = 0;
   localparam int IDX_LSB = 8;
   localparam int SUB_LSB = 24;
   localparam int VAL_LSB = 32;

   // frame lengths and fixed values
   localparam logic [3:0] LEN_FULL = 4'h8;
   localparam logic [3:0] LEN_BOOT = 4'h1;
   localparam logic [63:0] BOOT_DATA = 64'h0;
   localparam logic [31:0] STORE_SIGNATURE = 32'h55AAAA55;
   localparam logic [31:0] PRESET_MAX = 32'h00FFFFFF;

   ////////////////////////////////////////////////////////////////////////////
   // bit-rate selection codes, default station and core clock rate
   localparam logic [2:0] RATE_DEFAULT = 3'h3;
   localparam logic [7:0] RATE_CODE_MAX = 8'h07;
   localparam logic [7:0] STATION_DEFAULT = 8'h00;
   localparam int CLK_HZ = 100_000_000;

   // bit time in core clocks for each rate code
   function automatic int rate_cycles(input int clk_hz, input logic [2:0] code);
      int kbps;
      case (code)
         3'h0: kbps = 20;
         3'h1: kbps = 50;
         3'h2: kbps = 100;
         3'h3: kbps = 125;
         3'h4: kbps = 250;
         3'h5: kbps = 500;
         3'h6: kbps = 800;
         default: kbps = 1000;
      endcase
      return clk_hz / (kbps * 1000);
   endfunction

endpackage

// *** src/eoas_link_if.sv ***
// eoas_link_if: whole-frame link between the master and the encoder.
// assumes both ends run on the same core clock; transfer when valid and ready.
`timescale 1ns/1ps
interface eoas_link_if;
   // request frames, master to encoder
   logic req_valid;
   logic req_ready;
   logic req_ext;
   logic [10:0] req_id;
   logic [3:0] req_len;
   logic [63:0] req_data;
   // reply and boot frames, encoder to master
   logic rsp_valid;
   logic rsp_ready;
   logic [10:0] rsp_id;
   logic [3:0] rsp_len;
   logic [63:0] rsp_data;

   modport enc_end (
      input req_valid, req_ext, req_id, req_len, req_data, rsp_ready,
      output req_ready, rsp_valid, rsp_id, rsp_len, rsp_data
   );
   modport host_end (
      output req_valid, req_ext, req_id, req_len, req_data, rsp_ready,
      input req_ready, rsp_valid, rsp_id, rsp_len, rsp_data
   );
endinterface

// *** src/eoas_encoder_end.sv ***
// eoas_encoder_end: the encoder's object-access responder.
// assumes raw_pos and serial_no come from logic on core_clk, and that the
// stored settings on nv_* are stable from power-up onward.
`timescale 1ns/1ps

module eoas_encoder_end #(
   parameter int STEP_BITS = 12,
   parameter int TURN_BITS = 12,
   parameter int CLK_RATE_HZ = eoas_pkg::CLK_HZ
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // frame link
   eoas_link_if.enc_end link,
   // shaft and identity
   input wire logic [STEP_BITS+TURN_BITS-1:0] raw_pos,
   input wire logic [31:0] serial_no,
   // settings kept over power cycles
   input wire logic [7:0] nv_station,
   input wire logic [2:0] nv_rate,
   input wire logic [31:0] nv_preset,
   input wire logic [STEP_BITS+TURN_BITS-1:0] nv_offset,
   // settings to be written to storage
   output logic save_strobe,
   output logic [7:0] save_station,
   output logic [2:0] save_rate,
   output logic [31:0] save_preset,
   output logic [STEP_BITS+TURN_BITS-1:0] save_offset,
   // settings in force
   output logic [6:0] station_number,
   output logic [2:0] bit_rate_code,
   output logic bit_tick
);
   import eoas_pkg::*;

   localparam int PW = STEP_BITS + TURN_BITS;
   localparam logic [31:0] STEPS_PER_TURN = 32'(1) << STEP_BITS;
   localparam logic [31:0] TOTAL_SPAN = 32'(1) << PW;

   // refuse shapes the datapath or bit divider cannot hold
   if (PW > 31 || STEP_BITS < 1 || TURN_BITS < 1) begin : g_bad_width
      $error("position width must be 2 to 31 bits");
   end
   if (rate_cycles(CLK_RATE_HZ, 3'h0) > 65535 || rate_cycles(CLK_RATE_HZ, 3'h7) < 1) begin : g_bad_clk
      $error("clock rate out of range for the bit divider");
   end

   typedef enum logic [2:0] {ST_LOAD, ST_BOOT, ST_IDLE, ST_REPLY} eoas_enc_state_e;

   eoas_enc_state_e state_q;
   logic req_ready_q;
   logic rsp_valid_q;
   logic [10:0] rsp_id_q;
   logic [3:0] rsp_len_q;
   logic [63:0] rsp_data_q;
   logic [7:0] station_q;
   logic [6:0] station_out_q;
   logic [2:0] rate_q;
   logic [7:0] pend_station_q;
   logic [2:0] pend_rate_q;
   logic [31:0] preset_q;
   logic [PW-1:0] offset_q;
   logic [PW-1:0] pos_q;
   logic save_q;
   logic [7:0] save_station_q;
   logic [2:0] save_rate_q;
   logic [31:0] save_preset_q;
   logic [PW-1:0] save_offset_q;
   logic [15:0] div_q;
   logic tick_q;

   logic [10:0] own_id;
   logic [7:0] rq_cmd;
   logic [15:0] rq_idx;
   logic [7:0] rq_sub;
   logic [31:0] rq_val;
   logic frame_ok;
   logic take;
   logic is_read;
   logic ans_ok;
   logic [31:0] ans_val;
   logic wr_station;
   logic wr_rate;
   logic wr_preset;
   logic wr_store;

   ////////////////////////////////////////////////////////////////////////////
   // request fields and acceptance
   assign own_id = 11'(station_q) + 11'h001;
   assign rq_cmd = link.req_data[CMD_LSB +: 8];
   assign rq_idx = link.req_data[IDX_LSB +: 16];
   assign rq_sub = link.req_data[SUB_LSB +: 8];
   assign rq_val = link.req_data[VAL_LSB +: 32];
   assign is_read = (rq_cmd == CMD_READ);

   // foreign, extended or short frames are dropped silently
   assign frame_ok = !link.req_ext
      && (link.req_id == ID_REQ_BASE + own_id)
      && (link.req_len == LEN_FULL)
      && (is_read || rq_cmd == CMD_WRITE);
   assign take = (state_q == ST_IDLE) && link.req_valid && req_ready_q && frame_ok;

   ////////////////////////////////////////////////////////////////////////////
   // object decode: value for reads, accept strobes for writes
   always_comb begin
      ans_ok = 1'b1;
      ans_val = 32'h0;
      wr_station = 1'b0;
      wr_rate = 1'b0;
      wr_preset = 1'b0;
      wr_store = 1'b0;
      if (is_read) begin
         if (rq_idx == IDX_POSITION || rq_idx == IDX_POS_ALIAS) begin
            ans_val = 32'(pos_q);
         end else if (rq_idx == IDX_STEPS) begin
            ans_val = STEPS_PER_TURN;
         end else if (rq_idx == IDX_SPAN) begin
            ans_val = TOTAL_SPAN;
         end else if (rq_idx == IDX_SERIAL) begin
            ans_val = serial_no;
         end else if (rq_idx == IDX_PRESET) begin
            ans_val = preset_q;
         end else begin
            ans_ok = 1'b0;
         end
      end else begin
         if (rq_idx == IDX_STATION) begin
            wr_station = 1'b1;
         end else if (rq_idx == IDX_RATE) begin
            // codes above the table would be cut to three bits and select another rate
            ans_ok = (rq_val[7:0] <= RATE_CODE_MAX);
            wr_rate = ans_ok;
         end else if (rq_idx == IDX_PRESET) begin
            ans_ok = (rq_val <= PRESET_MAX);
            wr_preset = ans_ok;
         end else if (rq_idx == IDX_STORE) begin
            ans_ok = (rq_val == STORE_SIGNATURE);
            wr_store = ans_ok;
         end else begin
            ans_ok = 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // frame sequencer: load settings, boot frame, then serve requests
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_LOAD;
         req_ready_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         rsp_id_q <= 11'h000;
         rsp_len_q <= 4'h0;
         rsp_data_q <= 64'h0;
      end else begin
         case (state_q)
            ST_LOAD: begin
               state_q <= ST_BOOT;
            end
            ST_BOOT: begin
               rsp_valid_q <= 1'b1;
               rsp_id_q <= ID_BOOT_BASE + own_id;
               rsp_len_q <= LEN_BOOT;
               rsp_data_q <= BOOT_DATA;
               state_q <= ST_REPLY;
            end
            ST_IDLE: begin
               if (take) begin
                  req_ready_q <= 1'b0;
                  rsp_valid_q <= 1'b1;
                  rsp_id_q <= ID_RSP_BASE + own_id;
                  rsp_len_q <= LEN_FULL;
                  // echo index and subindex, value least byte first
                  rsp_data_q[IDX_LSB +: 16] <= rq_idx;
                  rsp_data_q[SUB_LSB +: 8] <= rq_sub;
                  rsp_data_q[VAL_LSB +: 32] <= ans_val;
                  if (!ans_ok) begin
                     rsp_data_q[CMD_LSB +: 8] <= CMD_ABORT;
                  end else if (is_read) begin
                     rsp_data_q[CMD_LSB +: 8] <= CMD_READ_ANS;
                  end else begin
                     rsp_data_q[CMD_LSB +: 8] <= CMD_WRITE_ANS;
                  end
                  state_q <= ST_REPLY;
               end else begin
                  req_ready_q <= 1'b1;
               end
            end
            ST_REPLY: begin
               if (link.rsp_ready) begin
                  rsp_valid_q <= 1'b0;
                  req_ready_q <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_LOAD;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // settings: loaded once after reset, pending values wait for a restart
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         station_q <= STATION_DEFAULT;
         station_out_q <= 7'(STATION_DEFAULT) + 7'h01;
         rate_q <= RATE_DEFAULT;
         pend_station_q <= STATION_DEFAULT;
         pend_rate_q <= RATE_DEFAULT;
         preset_q <= 32'h0;
         offset_q <= '0;
      end else if (state_q == ST_LOAD) begin
         station_q <= nv_station;
         station_out_q <= 7'(nv_station) + 7'h01;
         rate_q <= nv_rate;
         pend_station_q <= nv_station;
         pend_rate_q <= nv_rate;
         preset_q <= nv_preset;
         offset_q <= nv_offset;
      end else if (take) begin
         // station_q and rate_q stay put until the next power-up
         if (wr_station) begin
            pend_station_q <= rq_val[7:0];
         end
         if (wr_rate) begin
            pend_rate_q <= rq_val[2:0];
         end
         if (wr_preset) begin
            preset_q <= rq_val;
            offset_q <= rq_val[PW-1:0] - raw_pos;
         end
      end
   end

   // corrected position wraps at the full span
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pos_q <= '0;
      end else begin
         pos_q <= raw_pos + offset_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // store command: one strobe carrying every pending setting
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         save_q <= 1'b0;
         save_station_q <= STATION_DEFAULT;
         save_rate_q <= RATE_DEFAULT;
         save_preset_q <= 32'h0;
         save_offset_q <= '0;
      end else begin
         save_q <= take && wr_store;
         if (take && wr_store) begin
            save_station_q <= pend_station_q;
            save_rate_q <= pend_rate_q;
            save_preset_q <= preset_q;
            save_offset_q <= offset_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bit-time enable at the rate in force
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_q <= 16'h0000;
         tick_q <= 1'b0;
      end else if (div_q >= 16'(rate_cycles(CLK_RATE_HZ, rate_q) - 1)) begin
         div_q <= 16'h0000;
         tick_q <= 1'b1;
      end else begin
         div_q <= div_q + 16'h0001;
         tick_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign link.req_ready = req_ready_q;
   assign link.rsp_valid = rsp_valid_q;
   assign link.rsp_id = rsp_id_q;
   assign link.rsp_len = rsp_len_q;
   assign link.rsp_data = rsp_data_q;
   assign save_strobe = save_q;
   assign save_station = save_station_q;
   assign save_rate = save_rate_q;
   assign save_preset = save_preset_q;
   assign save_offset = save_offset_q;
   assign station_number = station_out_q;
   assign bit_rate_code = rate_q;
   assign bit_tick = tick_q;

endmodule

// *** src/eoas_host_end.sv ***
// eoas_host_end: master side, turns one command into one request frame and
// waits for the matching reply. assumes the user holds cmd_* while cmd_valid.
`timescale 1ns/1ps
module eoas_host_end #(
   parameter int RSP_TIMEOUT = 1024
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // frame link
   eoas_link_if.host_end link,
   // command
   input wire logic [6:0] target_station,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [15:0] cmd_index,
   input wire logic [7:0] cmd_sub,
   input wire logic [31:0] cmd_value,
   output logic cmd_ready,
   // answer
   output logic ans_valid,
   output logic ans_timeout,
   output logic [7:0] ans_cmd,
   output logic [31:0] ans_value,
   // boot notices
   output logic boot_seen,
   output logic [6:0] boot_station
);
   import eoas_pkg::*;

   if (RSP_TIMEOUT < 1 || RSP_TIMEOUT > 65535) begin : g_bad_timeout
      $error("RSP_TIMEOUT must be 1 to 65535");
   end

   typedef enum logic [1:0] {HS_IDLE, HS_SEND, HS_WAIT} eoas_host_state_e;

   eoas_host_state_e state_q;
   logic req_valid_q;
   logic [10:0] req_id_q;
   logic [63:0] req_data_q;
   logic [6:0] tgt_q;
   logic [15:0] wait_q;
   logic ready_q;
   logic ans_q;
   logic tmo_q;
   logic [7:0] ans_cmd_q;
   logic [31:0] ans_val_q;
   logic boot_q;
   logic [6:0] boot_st_q;
   logic rsp_fire;
   logic rsp_match;

   assign rsp_fire = link.rsp_valid;
   assign rsp_match = rsp_fire && link.rsp_len == LEN_FULL
      && link.rsp_id == ID_RSP_BASE + 11'(tgt_q);

   ////////////////////////////////////////////////////////////////////////////
   // request sequencer; always eight bytes, standard identifier
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= HS_IDLE;
         req_valid_q <= 1'b0;
         req_id_q <= 11'h000;
         req_data_q <= 64'h0;
         tgt_q <= 7'h00;
         wait_q <= 16'h0000;
         ready_q <= 1'b0;
         ans_q <= 1'b0;
         tmo_q <= 1'b0;
         ans_cmd_q <= 8'h00;
         ans_val_q <= 32'h0;
      end else begin
         ans_q <= 1'b0;
         tmo_q <= 1'b0;
         case (state_q)
            HS_IDLE: begin
               ready_q <= 1'b1;
               if (cmd_valid && ready_q) begin
                  ready_q <= 1'b0;
                  tgt_q <= target_station;
                  req_valid_q <= 1'b1;
                  req_id_q <= ID_REQ_BASE + 11'(target_station);
                  req_data_q[CMD_LSB +: 8] <= cmd_write ? CMD_WRITE : CMD_READ;
                  req_data_q[IDX_LSB +: 16] <= cmd_index;
                  req_data_q[SUB_LSB +: 8] <= cmd_sub;
                  req_data_q[VAL_LSB +: 32] <= cmd_write ? cmd_value : 32'h0;
                  state_q <= HS_SEND;
               end
            end
            HS_SEND: begin
               if (link.req_ready) begin
                  req_valid_q <= 1'b0;
                  wait_q <= 16'h0000;
                  state_q <= HS_WAIT;
               end
            end
            HS_WAIT: begin
               // a silent or absent station must not hang the master
               wait_q <= wait_q + 16'h0001;
               if (rsp_match) begin
                  ans_q <= 1'b1;
                  ans_cmd_q <= link.rsp_data[CMD_LSB +: 8];
                  ans_val_q <= link.rsp_data[VAL_LSB +: 32];
                  state_q <= HS_IDLE;
               end else if (wait_q >= 16'(RSP_TIMEOUT - 1)) begin
                  tmo_q <= 1'b1;
                  state_q <= HS_IDLE;
               end
            end
            default: begin
               state_q <= HS_IDLE;
            end
         endcase
      end
   end

   // boot frames may arrive at any time and are reported apart
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         boot_q <= 1'b0;
         boot_st_q <= 7'h00;
      end else begin
         boot_q <= rsp_fire && link.rsp_len == LEN_BOOT
            && link.rsp_id[10:7] == ID_BOOT_BASE[10:7];
         if (rsp_fire && link.rsp_id[10:7] == ID_BOOT_BASE[10:7]) begin
            boot_st_q <= link.rsp_id[6:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs; replies are always accepted at once
   assign link.req_valid = req_valid_q;
   assign link.req_ext = 1'b0;
   assign link.req_id = req_id_q;
   assign link.req_len = LEN_FULL;
   assign link.req_data = req_data_q;
   assign link.rsp_ready = 1'b1;
   assign cmd_ready = ready_q;
   assign ans_valid = ans_q;
   assign ans_timeout = tmo_q;
   assign ans_cmd = ans_cmd_q;
   assign ans_value = ans_val_q;
   assign boot_seen = boot_q;
   assign boot_station = boot_st_q;

endmodule

// *** tb/eoas_link_chk.sv ***
// eoas_link_chk: timing and content checks on the frame link.
// assumes one clock; the testbench wires in the link signals by name.
`timescale 1ns/1ps
module eoas_link_chk (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // request frames
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic req_ext,
   input wire logic [10:0] req_id,
   input wire logic [3:0] req_len,
   input wire logic [63:0] req_data,
   // reply frames
   input wire logic rsp_valid,
   input wire logic rsp_ready,
   input wire logic [10:0] rsp_id,
   input wire logic [3:0] rsp_len,
   input wire logic [63:0] rsp_data
);
   logic [6:0] stn_q;
   logic tk, rd, wr;
   logic [15:0] ix;
   ////////////////////////////////////////////////////////////
   // station learnt from the boot frame, as no settings reach here
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n)
         stn_q <= 7'h00;
      else if (rsp_valid && rsp_len == 4'h1)
         stn_q <= rsp_id[6:0];
   end
   // requests the encoder has to serve
   assign tk = req_valid && req_ready && !req_ext && req_len == 4'h8 && req_id == {4'hC, stn_q};
   assign rd = tk && req_data[7:0] == 8'h40;
   assign wr = tk && req_data[7:0] == 8'h22;
   assign ix = req_data[23:8];
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   a_reply_next: assert property ((rd || wr) |=> rsp_valid && rsp_id == {4'hB, stn_q})
      else $error("reply late or misaddressed");
   a_index_echo: assert property ((rd || wr) |=> rsp_data[31:8] == $past(req_data[31:8]))
      else $error("index not echoed");
   a_read_code: assert property (rd |=> rsp_data[7:0] inside {8'h43, 8'h80})
      else $error("bad read answer code");
   a_write_code: assert property (wr |=> rsp_data[7:0] inside {8'h60, 8'h80})
      else $error("bad write answer code");
   a_steps_value: assert property (rd && ix == 16'h2101
      |=> rsp_data[63:32] == 32'h00001000)
      else $error("wrong steps per turn");
   a_store_guard: assert property (wr && ix == 16'h2300
      && req_data[63:32] != 32'h55AAAA55 |=> rsp_data[7:0] == 8'h80)
      else $error("store taken without signature");
   a_drop_foreign: assert property (req_valid && req_ready && req_id[6:0] != stn_q
      |=> !rsp_valid)
      else $error("foreign request answered");
   a_boot_frame: assert property ($rose(arst_n) |-> ##[1:3] rsp_valid
      && rsp_len == 4'h1 && rsp_id[10:7] == 4'hE && rsp_data == 64'h0)
      else $error("no boot frame");
   a_request_shape: assert property (req_valid |-> req_len == 4'h8 && !req_ext)
      else $error("request not eight bytes in a standard frame");
   c_read: cover property (rd);
   c_write: cover property (wr);
   c_refused: cover property (rsp_valid && rsp_data[7:0] == 8'h80);
endmodule

// *** tb/testbench.sv ***
// testbench: host and encoder ends on one link, checked against a model.
// assumes package, interface, both ends and the checker compile first.
`timescale 1ns/1ps
module testbench;
   import eoas_pkg::*;
   logic core_clk, arst_n, save_strobe, bit_tick, cmd_valid, cmd_write, cmd_ready;
   logic ans_valid, ans_timeout, boot_seen;
   logic [23:0] raw_pos, nv_offset, save_offset;
   logic [31:0] serial_no, nv_preset, save_preset, cmd_value, ans_value, v, pos, pre;
   logic [7:0] nv_station, save_station, cmd_sub, ans_cmd, stn;
   logic [2:0] nv_rate, save_rate, bit_rate_code, code;
   logic [6:0] station_number, target_station, boot_station;
   logic [15:0] cmd_index;
   int err_count = 0;
   int tests_run = 0;
   int saves = 0;
   int tick_tab[$] = '{5000, 2000, 1000, 800, 400, 200, 125, 100};
   logic [15:0] rd_tab[$] = '{16'h2000, 16'h6004, 16'h2101, 16'h2102, 16'h650B, 16'h6003};
   eoas_link_if link ();
   eoas_encoder_end eoas_encoder_end_inst (.core_clk(core_clk), .arst_n(arst_n), .link(link),
      .raw_pos(raw_pos), .serial_no(serial_no), .nv_station(nv_station), .nv_rate(nv_rate),
      .nv_preset(nv_preset), .nv_offset(nv_offset), .save_strobe(save_strobe),
      .save_station(save_station), .save_rate(save_rate), .save_preset(save_preset),
      .save_offset(save_offset), .station_number(station_number),
      .bit_rate_code(bit_rate_code), .bit_tick(bit_tick));
   eoas_host_end #(.RSP_TIMEOUT(16)) eoas_host_end_inst (.core_clk(core_clk),
      .arst_n(arst_n), .link(link), .target_station(target_station), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_index(cmd_index), .cmd_sub(cmd_sub),
      .cmd_value(cmd_value), .cmd_ready(cmd_ready), .ans_valid(ans_valid),
      .ans_timeout(ans_timeout), .ans_cmd(ans_cmd), .ans_value(ans_value),
      .boot_seen(boot_seen), .boot_station(boot_station));
   eoas_link_chk eoas_link_chk_inst (.core_clk(core_clk), .arst_n(arst_n),
      .req_valid(link.req_valid), .req_ready(link.req_ready), .req_ext(link.req_ext),
      .req_id(link.req_id), .req_len(link.req_len), .req_data(link.req_data),
      .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready), .rsp_id(link.rsp_id),
      .rsp_len(link.rsp_len), .rsp_data(link.rsp_data));
   ////////////////////////////////////////////////////////////
   // free-running core clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // save pulses last one cycle, so count them as they pass
   always @(posedge core_clk) if (save_strobe === 1'b1) saves <= saves + 1;
   ////////////////////////////////////////////////////////////
   // model: position follows the last preset, raw count held still
   function automatic logic [31:0] exp_val(input logic [15:0] idx);
      case (idx)
         16'h2101: return 32'h00001000;
         16'h2102: return 32'h01000000;
         16'h650B: return serial_no;
         16'h6003: return pre;
         default: return pos;
      endcase
   endfunction
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic give_up();
      err_count++;
      $display("ERROR handshake expected 1 seen none");
      conclude();
   endtask
   // one command through the host end, held until taken
   task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] val);
      int n;
      for (n = 0; n < 60 && cmd_ready !== 1'b1; n++) @(posedge core_clk) #1;
      if (n == 60) give_up();
      cmd_write = w;
      cmd_index = idx;
      cmd_value = val;
      cmd_sub = 8'($urandom);
      cmd_valid = 1'b1;
      @(posedge core_clk) #1 cmd_valid = 1'b0;
      for (n = 0; n < 60 && (ans_valid | ans_timeout) !== 1'b1; n++) @(posedge core_clk) #1;
      if (n == 60) give_up();
   endtask
   task automatic rd(input logic [15:0] idx);
      xfer(1'b0, idx, 32'h0);
      chk("read code", CMD_READ_ANS, ans_cmd);
      chk("read value", exp_val(idx), ans_value);
   endtask
   task automatic wr(input logic [15:0] idx, input logic [31:0] val, input logic [7:0] ec);
      xfer(1'b1, idx, val);
      chk("write code", ec, ans_cmd);
   endtask
   // reset with given stored settings, then boot frame and bit timing
   task automatic boot(input logic [7:0] s, input logic [2:0] r);
      int n;
      arst_n = 1'b0;
      nv_station = s;
      nv_rate = r;
      repeat (6) @(posedge core_clk);
      #1 arst_n = 1'b1;
      for (n = 0; n < 20 && boot_seen !== 1'b1; n++) @(posedge core_clk) #1;
      if (n == 20) give_up();
      chk("boot station", {24'h0, s} + 32'h1, boot_station);
      chk("station", {24'h0, s} + 32'h1, station_number);
      chk("rate code", r, bit_rate_code);
      for (n = 0; n < 6000 && bit_tick !== 1'b1; n++) @(posedge core_clk) #1;
      for (n = 1; n < 6000; n++) begin
         @(posedge core_clk) #1;
         if (bit_tick === 1'b1) break;
      end
      chk("tick period", tick_tab[r], n);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(76115));
      {cmd_valid, cmd_write, cmd_index, cmd_sub, cmd_value} = '0;
      target_station = 7'h01;
      raw_pos = 24'($urandom);
      serial_no = $urandom;
      nv_preset = 32'h0;
      nv_offset = 24'h0;
      pos = {8'h00, raw_pos};
      pre = 32'h0;
      boot(8'h00, 3'h3);
      foreach (rd_tab[i]) rd(rd_tab[i]);
      v = {8'h00, 24'($urandom)};
      wr(IDX_PRESET, v, CMD_WRITE_ANS);
      pos = v;
      pre = v;
      rd(IDX_POSITION);
      wr(IDX_PRESET, 32'h01000000, CMD_ABORT);
      stn = 8'($urandom_range(126));
      code = 3'($urandom);
      wr(IDX_STATION, {24'h0, stn}, CMD_WRITE_ANS);
      wr(IDX_RATE, {29'h0, code}, CMD_WRITE_ANS);
      wr(IDX_RATE, 32'h00000008, CMD_ABORT);
      wr(IDX_STORE, 32'h55AAAA00, CMD_ABORT);
      chk("early save", 0, saves);
      wr(IDX_STORE, STORE_SIGNATURE, CMD_WRITE_ANS);
      chk("saves", 1, saves);
      chk("saved station", stn, save_station);
      chk("saved rate", code, save_rate);
      chk("station kept", 1, station_number);
      target_station = 7'h05;
      xfer(1'b0, IDX_POSITION, 32'h0);
      chk("foreign dropped", 1, ans_timeout);
      target_station = stn[6:0] + 7'h01;
      nv_preset = save_preset;
      nv_offset = save_offset;
      boot(stn, code);
      rd(IDX_POSITION);
      rd(IDX_PRESET);
      conclude();
   end
endmodule
